// ===== hdl/cc_bc_irq_pkg.sv
package cc_bc_irq_pkg;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [7:0] CHARGER_DETECT_IRQ_MASK_ADDR = 8'hcd; // Sits just below the CC mask
  localparam logic [7:0] TYPEC_IRQ_MASK_ADDR = 8'hce;
  localparam logic [7:0] CHARGER_DETECT_STATUS_ADDR = 8'hcf;
  localparam logic [7:0] TYPEC_CONNECTION_STATUS_ADDR = 8'hd0;
  localparam logic [7:0] TYPEC_COMPARATOR_STATUS_ADDR = 8'hd1;
  localparam logic [7:0] CHARGER_DETECT_IRQ_FLAG_ADDR = 8'hcb;
  localparam logic [7:0] TYPEC_IRQ_FLAG_ADDR = 8'hcc;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int VBUS_PRESENT_BIT = 7;
  localparam int PROPRIETARY_ADAPTER_BIT = 2;
  localparam int CONTACT_TIMEOUT_BIT = 2;
  localparam int CONTACT_TIMEOUT_IRQ_BIT = 1;
  localparam int ADAPTER_TYPE_BIT = 0;
  localparam int SAFE_ZERO_VOLT_BIT = 6;
  localparam int DETECT_ABORT_BIT = 5;
  localparam int ACTIVE_LINE_BIT = 3;
  localparam int CURRENT_CAPABILITY_BIT = 2;
  localparam int CONNECTION_STATE_BIT = 0;
  localparam int LINE1_RA_BIT = 7;
  localparam int LINE2_RA_BIT = 6;
  localparam int SAFE_ZERO_VOLT_STATUS_BIT = 3;
  localparam int DETECT_ABORT_STATUS_BIT = 2;

  // ************************************************************
  // Reset values and implemented-bit masks
  // ************************************************************
  localparam logic [7:0] CHARGER_DETECT_MASK_RESET = 8'h87;
  localparam logic [7:0] TYPEC_MASK_RESET = 8'h6d;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // ************************************************************
  // Field encodings
  // ************************************************************
  localparam logic [1:0] LINE_NONE = 2'h0;
  localparam logic [1:0] LINE_CC1 = 2'h1;
  localparam logic [1:0] LINE_CC2 = 2'h2;
  localparam logic [1:0] CURRENT_NOT_UFP = 2'h0;
  localparam logic [1:0] CURRENT_500MA = 2'h1;
  localparam logic [1:0] CURRENT_1A5 = 2'h2;
  localparam logic [1:0] CURRENT_3A0 = 2'h3;
  localparam logic [2:0] CONN_NONE = 3'h0;
  localparam logic [2:0] CONN_SINK = 3'h1;
  localparam logic [2:0] CONN_SOURCE = 3'h2;

  // Analog front end results, all asynchronous to core_clk
  typedef struct packed {
    logic vbus_present;       // VBUS above detect threshold
    logic line1_above_low;    // CC1 above 200mV comparator
    logic line1_above_high;   // CC1 above 600mV comparator
    logic line2_above_low;    // CC2 above 200mV comparator
    logic line2_above_high;   // CC2 above 600mV comparator
    logic safe_zero_volt;     // VBUS above safe-zero level
  } analog_in_s;

  // Results from the CC state machine, same clock domain
  typedef struct packed {
    logic [1:0] active_line;
    logic [1:0] current_capability;
    logic [2:0] connection_state;
    logic detect_abort;
  } typec_state_s;

  // Charger detection engine events, same clock domain
  typedef struct packed {
    logic contact_timeout;    // One-cycle pulse on DCD timeout
    logic detect_start;       // One-cycle pulse at start of a detection
    logic adapter_type_done;  // One-cycle pulse: type found
    logic proprietary_done;   // One-cycle pulse: proprietary type found
  } charger_event_s;

endpackage

// ===== hdl/cc_bc_irq_mask_status_regs.sv
`timescale 1ns/10ps
module cc_bc_irq_mask_status_regs
  import cc_bc_irq_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Register port from the serial interface
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Inputs from the analog and detection logic
  input wire analog_in_s analog_in,
  input wire typec_state_s typec_state,
  input wire charger_event_s charger_event,
  input wire logic sink_detect_low_power,
  input wire logic abort_bypass,
  // Outputs to the detection engine and pin
  output logic charger_detect_abort,
  output logic irq_n
);

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  analog_in_s analog_meta_reg; // First stage, read only by second stage
  analog_in_s analog_sync_reg; // Safe to use
  analog_in_s analog_prev_reg; // For edge detection

  // Two flops on every analog comparator output
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      analog_meta_reg <= '0;
      analog_sync_reg <= '0;
      analog_prev_reg <= '0;
    end
    else
    begin
      analog_meta_reg <= analog_in;
      analog_sync_reg <= analog_meta_reg;
      analog_prev_reg <= analog_sync_reg;
    end
  end

  // ************************************************************
  // Access decode
  // ************************************************************
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
    hit = (addr == target);
  endfunction

  // ************************************************************
  // Mask registers
  // ************************************************************
  logic [7:0] charger_mask_reg;
  logic [7:0] typec_mask_reg;

  // Charger mask: only implemented bits stored, others read zero
  always_ff @(posedge core_clk)
  begin
    if (reset)
      charger_mask_reg <= CHARGER_DETECT_MASK_RESET;
    else if (reg_write && hit(reg_addr, CHARGER_DETECT_IRQ_MASK_ADDR))
      charger_mask_reg <= reg_wdata & CHARGER_DETECT_MASK_RESET;
  end

  // CC mask: software clears a bit to unmask its source
  always_ff @(posedge core_clk)
  begin
    if (reset)
      typec_mask_reg <= TYPEC_MASK_RESET;
    else if (reg_write && hit(reg_addr, TYPEC_IRQ_MASK_ADDR))
      typec_mask_reg <= reg_wdata & TYPEC_MASK_RESET;
  end

  // ************************************************************
  // Status registers
  // ************************************************************
  logic contact_timeout_reg;
  logic [7:0] typec_conn_reg;
  logic [7:0] typec_comp_reg;
  logic [7:0] charger_status_reg;
  logic line1_ra;
  logic line2_ra;
  typec_state_s typec_prev_reg;

  // Threshold picked by the low-power sink-detect setting
  assign line1_ra = sink_detect_low_power ? analog_sync_reg.line1_above_high
                                          : analog_sync_reg.line1_above_low;
  assign line2_ra = sink_detect_low_power ? analog_sync_reg.line2_above_high
                                          : analog_sync_reg.line2_above_low;

  // Timeout sticks until the next detection begins
  always_ff @(posedge core_clk)
  begin
    if (reset)
      contact_timeout_reg <= 1'b0;
    else if (charger_event.contact_timeout)
      contact_timeout_reg <= 1'b1;
    else if (charger_event.detect_start)
      contact_timeout_reg <= 1'b0;
  end

  // Status snapshots; writes never reach them
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      charger_status_reg <= ZERO_BYTE;
      typec_conn_reg <= ZERO_BYTE;
      typec_comp_reg <= ZERO_BYTE;
      typec_prev_reg <= '0;
    end
    else
    begin
      charger_status_reg <= {analog_sync_reg.vbus_present, 4'h0, contact_timeout_reg, 2'h0};
      typec_conn_reg <= {typec_state.active_line, typec_state.current_capability, 1'b0,
                         typec_state.connection_state};
      typec_comp_reg <= {line1_ra, line2_ra, 2'h0, analog_sync_reg.safe_zero_volt,
                         typec_state.detect_abort, 2'h0};
      typec_prev_reg <= typec_state;
    end
  end

  // ************************************************************
  // Abort of charger detection
  // ************************************************************
  // Held level: stops a run in progress and blocks new ones
  always_ff @(posedge core_clk)
  begin
    if (reset)
      charger_detect_abort <= 1'b0;
    else
      charger_detect_abort <= typec_state.detect_abort && !abort_bypass;
  end

  // ************************************************************
  // Interrupt flags
  // ************************************************************
  logic [7:0] charger_flag_reg;
  logic [7:0] typec_flag_reg;
  logic [7:0] charger_set;
  logic [7:0] typec_set;
  logic charger_clear;
  logic typec_clear;

  // Event sources routed to their flag positions
  always_comb
  begin
    charger_set = ZERO_BYTE;
    charger_set[VBUS_PRESENT_BIT] = analog_sync_reg.vbus_present ^ analog_prev_reg.vbus_present;
    charger_set[PROPRIETARY_ADAPTER_BIT] = charger_event.proprietary_done;
    charger_set[CONTACT_TIMEOUT_IRQ_BIT] = charger_event.contact_timeout;
    charger_set[ADAPTER_TYPE_BIT] = charger_event.adapter_type_done;
    typec_set = ZERO_BYTE;
    typec_set[SAFE_ZERO_VOLT_BIT] = analog_sync_reg.safe_zero_volt ^ analog_prev_reg.safe_zero_volt;
    typec_set[DETECT_ABORT_BIT] = typec_state.detect_abort ^ typec_prev_reg.detect_abort;
    typec_set[ACTIVE_LINE_BIT] = typec_state.active_line != typec_prev_reg.active_line;
    typec_set[CURRENT_CAPABILITY_BIT] =
      typec_state.current_capability != typec_prev_reg.current_capability;
    typec_set[CONNECTION_STATE_BIT] =
      typec_state.connection_state != typec_prev_reg.connection_state;
  end

  assign charger_clear = reg_read && hit(reg_addr, CHARGER_DETECT_IRQ_FLAG_ADDR);
  assign typec_clear = reg_read && hit(reg_addr, TYPEC_IRQ_FLAG_ADDR);

  // Read clears all; a same-cycle event still lands
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      charger_flag_reg <= ZERO_BYTE;
      typec_flag_reg <= ZERO_BYTE;
    end
    else
    begin
      charger_flag_reg <= (charger_clear ? ZERO_BYTE : charger_flag_reg) | charger_set;
      typec_flag_reg <= (typec_clear ? ZERO_BYTE : typec_flag_reg) | typec_set;
    end
  end

  // Masked flags latch but do not pull the pin
  always_ff @(posedge core_clk)
  begin
    if (reset)
      irq_n <= 1'b1;
    else
      irq_n <= !(|(charger_flag_reg & ~charger_mask_reg) || |(typec_flag_reg & ~typec_mask_reg));
  end

  // ************************************************************
  // Read data
  // ************************************************************
  // Registered read; unmapped addresses return zero
  always_ff @(posedge core_clk)
  begin
    if (reset)
      reg_rdata <= ZERO_BYTE;
    else if (reg_read)
    begin
      unique case (1'b1)
        hit(reg_addr, CHARGER_DETECT_IRQ_MASK_ADDR): reg_rdata <= charger_mask_reg;
        hit(reg_addr, TYPEC_IRQ_MASK_ADDR): reg_rdata <= typec_mask_reg;
        hit(reg_addr, CHARGER_DETECT_STATUS_ADDR): reg_rdata <= charger_status_reg;
        hit(reg_addr, TYPEC_CONNECTION_STATUS_ADDR): reg_rdata <= typec_conn_reg;
        hit(reg_addr, TYPEC_COMPARATOR_STATUS_ADDR): reg_rdata <= typec_comp_reg;
        hit(reg_addr, CHARGER_DETECT_IRQ_FLAG_ADDR): reg_rdata <= charger_flag_reg;
        hit(reg_addr, TYPEC_IRQ_FLAG_ADDR): reg_rdata <= typec_flag_reg;
        default: reg_rdata <= ZERO_BYTE;
      endcase
    end
  end

endmodule // cc_bc_irq_mask_status_regs

// ===== sim/cc_bc_irq_mask_status_regs_assertions.sv
`timescale 1ns/10ps
// ************************************************************
// Port checker
// ************************************************************
module cc_bc_irq_mask_status_regs_assertions
  import cc_bc_irq_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Register port
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Front end and state machine
  input wire analog_in_s analog_in,
  input wire typec_state_s typec_state,
  input wire charger_event_s charger_event,
  input wire logic sink_detect_low_power,
  input wire logic abort_bypass,
  // Outputs
  input wire logic charger_detect_abort,
  input wire logic irq_n
);
  default clocking cb_chk @(posedge core_clk); endclocking
  default disable iff (reset);
  logic unmasked_reg; // Set once software touches a mask
  logic [1:0] ra_exp; // Selected comparator pair
  logic [7:0] conn_exp; // Expected connection byte
  // Comparator pick follows the low-power setting
  assign ra_exp = sink_detect_low_power ? {analog_in.line1_above_high, analog_in.line2_above_high}
    : {analog_in.line1_above_low, analog_in.line2_above_low};
  assign conn_exp = {typec_state.active_line, typec_state.current_capability, 1'b0, typec_state.connection_state};
  // Masks stay all set until a mask write
  always_ff @(posedge core_clk)
  begin
    if (reset)
      unmasked_reg <= 1'b0;
    else if (reg_write && (reg_addr == CHARGER_DETECT_IRQ_MASK_ADDR || reg_addr == TYPEC_IRQ_MASK_ADDR))
      unmasked_reg <= 1'b1;
  end
  // Front end held still long enough to cross the synchronisers
  sequence front_steady;
    ($stable(analog_in) && $stable(sink_detect_low_power))[*5];
  endsequence
  sequence comp_read;
    reg_read && reg_addr == TYPEC_COMPARATOR_STATUS_ADDR;
  endsequence
  a_rdata_hold_idle: assert property (!reg_read |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_unmapped_read_zero: assert property (reg_read && (reg_addr < 8'hcb || reg_addr > 8'hd1)
    |=> reg_rdata == ZERO_BYTE) else $error("unmapped read not zero");
  a_cc_mask_bits: assert property (reg_read && reg_addr == TYPEC_IRQ_MASK_ADDR
    |=> (reg_rdata & ~TYPEC_MASK_RESET) == ZERO_BYTE) else $error("unused mask bit set");
  a_conn_status_readback: assert property ($stable(typec_state) && !$past(reset)
    && reg_read && reg_addr == TYPEC_CONNECTION_STATUS_ADDR |=> reg_rdata == $past(conn_exp))
    else $error("connection status mismatch");
  a_comparator_select: assert property (front_steady ##0 comp_read
    |=> reg_rdata[7:6] == $past(ra_exp)) else $error("comparator bits mismatch");
  a_abort_blocks_detect: assert property ((typec_state.detect_abort && !abort_bypass)[*4]
    |-> charger_detect_abort) else $error("abort not passed on");
  a_bypass_frees_detect: assert property (abort_bypass[*4] |-> !charger_detect_abort)
    else $error("abort seen while bypassed");
  a_masked_irq_quiet: assert property (!unmasked_reg |-> irq_n)
    else $error("interrupt while all masked");
endmodule // cc_bc_irq_mask_status_regs_assertions

bind cc_bc_irq_mask_status_regs cc_bc_irq_mask_status_regs_assertions i_cc_bc_irq_mask_status_regs_assertions (
  .core_clk, .reset, .reg_write, .reg_read, .reg_addr, .reg_wdata, .reg_rdata, .analog_in, .typec_state,
  .charger_event, .sink_detect_low_power, .abort_bypass, .charger_detect_abort, .irq_n);

// ===== sim/cc_bc_irq_mask_status_regs_tb_top.sv
`timescale 1ns/10ps
// ************************************************************
// Self-checking bench
// ************************************************************
module cc_bc_irq_mask_status_regs_tb_top import cc_bc_irq_pkg::*;;
  logic core_clk = 1'b0; // 125 MHz
  logic reset = 1'b1;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  analog_in_s analog_in = '0;
  typec_state_s typec_state = '0;
  charger_event_s charger_event = '0;
  logic sink_detect_low_power = 1'b0;
  logic abort_bypass = 1'b0;
  logic charger_detect_abort;
  logic irq_n;
  int n_errors = 0;
  int checked = 0;
  logic [7:0] rd_data; // Never assigned; rdchk checks reg_rdata directly
  // Map walk: flags, masks, status, one hole
  logic [7:0] ad [8] = '{8'hcb, 8'hcc, 8'hcd, 8'hce, 8'hcf, 8'hd0, 8'hd1, 8'he0};
  logic [7:0] ex [8] = '{8'h00, 8'h00, 8'h87, 8'h6d, 8'h00, 8'h00, 8'h00, 8'h00};
  cc_bc_irq_mask_status_regs i_cc_bc_irq_mask_status_regs (.core_clk, .reset, .reg_write, .reg_read,
    .reg_addr, .reg_wdata, .reg_rdata, .analog_in, .typec_state, .charger_event, .sink_detect_low_power,
    .abort_bypass, .charger_detect_abort, .irq_n);
  initial forever #4 core_clk = ~core_clk;
  // Strobes last one cycle; a gap cycle keeps drivers single per step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_write = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge core_clk);
    reg_write = 1'b0;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Read data is checked half a cycle after the taking edge
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge core_clk);
    reg_read = 1'b1;
    reg_addr = a;
    @(negedge core_clk);
    reg_read = 1'b0;
    chk8(reg_rdata, exp);
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Watchdog: the sequence needs well under a thousand cycles
  initial
  begin
    repeat (3000) @(posedge core_clk);
    n_errors++;
    print_verdict();
  end
  initial
  begin
    wait_n(12);
    reset = 1'b0;
    for (int i = 0; i < 8; i++)
      rdchk(ad[i], ex[i]);
    chk8({7'h00, irq_n}, 8'h01);
    // Masks: only implemented bits stick, zero unmasks
    for (int i = 2; i < 4; i++)
    begin
      wr(ad[i], 8'hff);
      rdchk(ad[i], ex[i]);
      wr(ad[i], 8'h00);
      rdchk(ad[i], 8'h00);
      wr(ad[i], 8'hff);
    end
    // Status and hole ignore writes
    for (int i = 4; i < 8; i++)
    begin
      wr(ad[i], 8'hff);
      rdchk(ad[i], 8'h00);
    end
    // Codes 0 to 3 of each of the three connection fields
    for (int i = 0; i < 4; i++)
    begin
      typec_state = {i[1:0], 2'(3 - i), i[2:0], 1'b0};
      wait_n(3);
      rdchk(8'hd0, {i[1:0], 2'(3 - i), 1'b0, i[2:0]});
    end
    rdchk(8'hcc, 8'h0d);
    chk8({7'h00, irq_n}, 8'h01);
    rdchk(8'hcc, 8'h00);
    // Abort blocks detection unless bypassed
    typec_state.detect_abort = 1'b1;
    wait_n(4);
    chk8({7'h00, charger_detect_abort}, 8'h01);
    rdchk(8'hd1, 8'h04);
    abort_bypass = 1'b1;
    wait_n(5);
    chk8({7'h00, charger_detect_abort}, 8'h00);
    abort_bypass = 1'b0;
    typec_state.detect_abort = 1'b0;
    wait_n(4);
    chk8({7'h00, charger_detect_abort}, 8'h00);
    rdchk(8'hcc, 8'h20);
    // Unmasked timeout reaches the pin, read clears it
    wr(8'hcd, 8'hfd);
    charger_event.contact_timeout = 1'b1;
    wait_n(1);
    charger_event.contact_timeout = 1'b0;
    wait_n(3);
    chk8({7'h00, irq_n}, 8'h00);
    rdchk(8'hcf, 8'h04);
    rdchk(8'hcb, 8'h02);
    wait_n(2);
    chk8({7'h00, irq_n}, 8'h01);
    rdchk(8'hcf, 8'h04);
    charger_event.detect_start = 1'b1;
    wait_n(1);
    charger_event.detect_start = 1'b0;
    wait_n(3);
    rdchk(8'hcf, 8'h00);
    wr(8'hcd, 8'hff);
    // Comparator pair under both threshold settings
    analog_in = 6'b101111;
    for (int s = 0; s < 2; s++)
    begin
      sink_detect_low_power = s[0];
      wait_n(6);
      rdchk(8'hd1, s[0] ? 8'hc8 : 8'h48);
    end
    // Type results and the front-end changes latch while masked
    charger_event.adapter_type_done = 1'b1;
    charger_event.proprietary_done = 1'b1;
    wait_n(1);
    charger_event.adapter_type_done = 1'b0;
    charger_event.proprietary_done = 1'b0;
    wait_n(3);
    chk8({7'h00, irq_n}, 8'h01);
    rdchk(8'hcf, 8'h80);
    // Unmasking only the VBUS source pulls the pin
    wr(8'hcd, 8'h7f);
    wait_n(2);
    chk8({7'h00, irq_n}, 8'h00);
    rdchk(8'hcb, 8'h85);
    rdchk(8'hcc, 8'h40);
    wait_n(2);
    chk8({7'h00, irq_n}, 8'h01);
    print_verdict();
  end
endmodule // cc_bc_irq_mask_status_regs_tb_top
